// [core/csc_alert_src.sv]
// one alert source: rising edge detect and clear-on-read flag
`timescale 1ns/100ps
module csc_alert_src
(
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic stat_i,
  input  wire logic flag_rd_i,
  output logic      flag_o,
  output logic      rise_o
);

  logic prev;
  logic next_prev;
  logic next_flag;

  // ****************************************************************
  // edge and flag
  // ****************************************************************
  // a new edge in the read cycle wins, so no event is lost
  always_comb
  begin
    rise_o    = stat_i & ~prev;
    next_prev = stat_i;
    next_flag = (flag_o & ~flag_rd_i) | rise_o; // see RL9
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      prev   <= 1'b0;
      flag_o <= 1'b0;
    end
    else
    begin
      prev   <= next_prev;
      flag_o <= next_flag;
    end
  end

endmodule

// [core/csc_top.sv]
// charger supervisory logic
// What this block does
// RL1: indicator low while charging, else released
// RL2: indicator blinks 1 Hz on fault suspend
// RL3: disable bit silences the indicator pin
// RL4: one 256 us low alert per event, events during a pulse share one follow-up
// RL5: listed conditions each raise an alert
// RL6: watchdog expiry and power-up raise alert
// RL7: other status rising edges also alert
// RL8: status, flag and mask per source
// RL9: flags clear on read, set by edges
// RL10: mode field resets to idle, switch on
// RL11: shutdown mode, adapter wakes, field returns idle
// RL12: ship mode turns switches off, slow clock
// RL13: shutdown or ship refused while bus high
// RL14: switch off immediately or after 10 s
// RL15: ship exit by adapter, write, reset, button
// RL16: power reset: switch off 350 ms
// RL17: battery switch kept, field back idle
// RL18: line overvoltage opens that input path
// RL19: bus overvoltage stops converter until cleared
// RL20: weak source stops converter, retest 7 min
// RL21: system overvoltage stops converter until cleared
// RL22: system short limits converter output current
// RL23: blink and pulse timed by clock counters
// RL24: host reads flags after alert edge
`timescale 1ns/100ps
`include "csc_regs.svh"
module csc_top
#(
  parameter int unsigned MS_TICK_CYC = `CSC_MS_NS / `CSC_CLK_PERIOD_NS,
  parameter int unsigned ALERT_CYC   = (`CSC_ALERT_US * 1000) / `CSC_CLK_PERIOD_NS
)
(
  input  wire logic                   clk_i,
  input  wire logic                   srst_i,
  input  wire csc_pkg::csc_cond_s     cond_i,
  input  wire logic                   charging_i,
  input  wire logic                   fault_suspend_i,
  input  wire logic                   indicator_disable_bit_i,
  input  wire logic [`CSC_NSRC-1:0]   mask_i,
  input  wire logic [`CSC_NSRC-1:0]   flag_rd_i,
  input  wire logic                   mode_wr_i,
  input  wire logic [1:0]             mode_wdata_i,
  input  wire logic                   reg_reset_i,
  input  wire logic                   ship_off_delay_select_i,
  input  wire logic                   wake_hold_time_select_i,
  input  wire logic                   wake_button_pin_n_i,
  input  wire logic                   adapter_present_i,
  input  wire logic                   reverse_boost_mode_i,
  input  wire logic                   battery_switch_req_i,
  input  wire logic [1:0]             input_valid_i,
  output logic                        stat_pin_o,
  output logic                        stat_pin_oe_o,
  output logic                        alert_n_o,
  output logic [`CSC_NSRC-1:0]        status_o,
  output logic [`CSC_NSRC-1:0]        flag_o,
  output logic [1:0]                  ship_switch_mode_field_o,
  output csc_pkg::csc_power_s         power_o
);

  // ****************************************************************
  // millisecond tick
  // ****************************************************************
  logic [17:0] tick_cnt;
  logic [17:0] next_tick_cnt;
  logic        ms_tick;

  // slow times count in ms so no counter grows past 20 bits
  always_comb
  begin
    ms_tick       = (tick_cnt == 18'(MS_TICK_CYC - 1));
    next_tick_cnt = ms_tick ? 18'h00000 : tick_cnt + 18'h00001; // see RL23
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      tick_cnt <= 18'h00000;
    else
      tick_cnt <= next_tick_cnt;
  end

  // ****************************************************************
  // alert sources
  // ****************************************************************
  logic [`CSC_NSRC-1:0] live;
  logic [`CSC_NSRC-1:0] rise;
  logic [2:0]           kind_prev;
  logic [2:0]           phase_prev;
  logic [3:0]           zone_prev;
  logic                 seen_good;
  logic                 por_seen;
  logic                 next_seen_good;

  // field changes are one-cycle pulses
  always_comb
  begin
    live                     = '0;
    live[`CSC_SRC_GOOD_IN]   = cond_i.good_input; // see RL5
    live[`CSC_SRC_GOOD_GONE] = seen_good & ~cond_i.good_input; // see RL5
    live[`CSC_SRC_KIND_CHG]  = kind_prev != cond_i.input_source_kind_field;
    live[`CSC_SRC_IIN_LOOP]  = cond_i.input_current_limit_loop;
    live[`CSC_SRC_VIN_LOOP]  = cond_i.input_voltage_limit_loop;
    live[`CSC_SRC_DIE_HEAT]  = cond_i.die_heat_regulation;
    live[`CSC_SRC_WATCHDOG]  = cond_i.watchdog_expired | ~por_seen;     // see RL6
    live[`CSC_SRC_PHASE_CHG] = phase_prev != cond_i.charge_phase_field;
    live[`CSC_SRC_ZONE_CHG]  = zone_prev != cond_i.thermistor_zone_field;
    live[`CSC_SRC_BUS_OVP]   = cond_i.bus_overvoltage_fault;
    live[`CSC_SRC_LINE_OVP0] = cond_i.input_line_overvoltage_fault[0];
    live[`CSC_SRC_LINE_OVP1] = cond_i.input_line_overvoltage_fault[1];
    live[`CSC_SRC_DIE_OFF]   = cond_i.die_overheat_cutoff;
    live[`CSC_SRC_BAT_OVP]   = cond_i.battery_overvoltage_fault;
    live[`CSC_SRC_SYS_OVP]   = cond_i.system_overvoltage_fault;
    live[`CSC_SRC_IN_OCP]    = cond_i.input_overcurrent_fault;
    live[`CSC_SRC_BAT_OCP]   = cond_i.battery_overcurrent_fault;
    live[`CSC_SRC_SAFETY]    = cond_i.safety_timer_expired;
    live[`CSC_SRC_SYS_SHORT] = cond_i.system_short_fault;
    live[`CSC_SRC_WEAK]      = cond_i.weak_source_fail;
    live[`CSC_SRC_OTHER0]    = cond_i.other_status[0]; // see RL7
    live[`CSC_SRC_OTHER1]    = cond_i.other_status[1]; // see RL7
    next_seen_good           = seen_good | cond_i.good_input;
  end

  // removal counts only after an input was seen
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      kind_prev  <= 3'h0;
      phase_prev <= 3'h0;
      zone_prev  <= 4'h0;
      seen_good  <= 1'b0;
      por_seen   <= 1'b0;
      status_o   <= '0;
    end
    else
    begin
      kind_prev  <= cond_i.input_source_kind_field;
      phase_prev <= cond_i.charge_phase_field;
      zone_prev  <= cond_i.thermistor_zone_field;
      seen_good  <= next_seen_good;
      por_seen   <= 1'b1;
      status_o   <= live; // see RL8
    end
  end

  // one edge and flag cell per source
  genvar gi;
  generate
    for (gi = 0; gi < `CSC_NSRC; gi++)
    begin : g_src
      csc_alert_src u_src
      (
        .clk_i     (clk_i),
        .srst_i    (srst_i),
        .stat_i    (live[gi]),
        .flag_rd_i (flag_rd_i[gi]),
        .flag_o    (flag_o[gi]),
        .rise_o    (rise[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // alert pulse
  // ****************************************************************
  logic [15:0] alert_cnt;
  logic [15:0] next_alert_cnt;
  logic        alert_pend;
  logic        next_alert_pend;
  logic        fire;

  // events during a pulse merge into one follow-up pulse after a high cycle
  always_comb
  begin
    fire            = |(rise & ~mask_i); // see RL8
    next_alert_cnt  = alert_cnt;
    next_alert_pend = alert_pend | fire;
    if (alert_cnt != 16'h0000)
      next_alert_cnt = alert_cnt - 16'h0001;
    else if (fire | alert_pend)
    begin
      next_alert_cnt  = 16'(ALERT_CYC); // see RL4
      next_alert_pend = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      alert_cnt  <= 16'h0000;
      alert_pend <= 1'b0;
      alert_n_o  <= 1'b1;
    end
    else
    begin
      alert_cnt  <= next_alert_cnt;
      alert_pend <= next_alert_pend;
      alert_n_o  <= (next_alert_cnt == 16'h0000); // see RL4
    end
  end

  // ****************************************************************
  // charge indicator pin
  // ****************************************************************
  logic [19:0] blink_ms;
  logic [19:0] next_blink_ms;
  logic        blink_ph;
  logic        next_blink_ph;
  logic        next_stat_oe;

  // open drain: the pin only ever pulls low, oe high means pulled low
  always_comb
  begin
    next_blink_ms = blink_ms;
    next_blink_ph = blink_ph;
    if (~fault_suspend_i)
    begin
      next_blink_ms = 20'h00000;
      next_blink_ph = 1'b0;
    end
    else if (ms_tick)
    begin
      if (blink_ms == `CSC_BLINK_HALF_MS - 20'h00001)
      begin
        next_blink_ms = 20'h00000;
        next_blink_ph = ~blink_ph; // see RL2
      end
      else
        next_blink_ms = blink_ms + 20'h00001;
    end
    if (indicator_disable_bit_i)
      next_stat_oe = 1'b0; // see RL3
    else if (fault_suspend_i)
      next_stat_oe = ~blink_ph; // see RL2
    else
      next_stat_oe = charging_i; // see RL1
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      blink_ms      <= 20'h00000;
      blink_ph      <= 1'b0;
      stat_pin_oe_o <= 1'b0;
      stat_pin_o    <= 1'b0;
    end
    else
    begin
      blink_ms      <= next_blink_ms;
      blink_ph      <= next_blink_ph;
      stat_pin_oe_o <= next_stat_oe;
      stat_pin_o    <= 1'b0;
    end
  end

  // ****************************************************************
  // ship switch sequencer
  // ****************************************************************
  csc_pkg::csc_state_e state;
  csc_pkg::csc_state_e next_state;
  logic [1:0]          mode;
  logic [1:0]          next_mode;
  logic [1:0]          target;
  logic [1:0]          next_target;
  logic [19:0]         seq_ms;
  logic [19:0]         next_seq_ms;
  logic [19:0]         btn_ms;
  logic [19:0]         next_btn_ms;
  logic                batt_hold;
  logic                next_batt_hold;
  logic                bus_high;
  logic                long_hold;
  logic                wake_hold;

  // button hold counter saturates so the 10 s event fires only once
  always_comb
  begin
    bus_high    = adapter_present_i | reverse_boost_mode_i;
    next_btn_ms = btn_ms;
    if (wake_button_pin_n_i)
      next_btn_ms = 20'h00000;
    else if (ms_tick & (btn_ms != `CSC_RST_HOLD_MS))
      next_btn_ms = btn_ms + 20'h00001;
    long_hold = ms_tick & ~wake_button_pin_n_i & (btn_ms == `CSC_RST_HOLD_MS - 20'h00001);
    wake_hold = btn_ms >= (wake_hold_time_select_i ? `CSC_WAKE_SHORT_MS : `CSC_WAKE_LONG_MS);
  end

  // next state and mode field
  always_comb
  begin
    next_state     = state;
    next_mode      = mode;
    next_target    = target;
    next_seq_ms    = seq_ms;
    next_batt_hold = batt_hold;
    unique case (state)
      csc_pkg::CSC_ST_IDLE:
      begin
        if (mode_wr_i & (mode_wdata_i != `CSC_MODE_IDLE))
        begin
          if ((mode_wdata_i != `CSC_MODE_PRST) & bus_high)
            next_mode = `CSC_MODE_IDLE;  // see RL13
          else
          begin
            next_mode   = mode_wdata_i;
            next_target = mode_wdata_i;
            next_seq_ms = 20'h00000;
            next_state  = csc_pkg::CSC_ST_DELAY; // see RL14
          end
        end
      end
      csc_pkg::CSC_ST_DELAY:
      begin
        if (mode_wr_i & (mode_wdata_i == `CSC_MODE_IDLE))
        begin
          next_mode  = `CSC_MODE_IDLE;
          next_state = csc_pkg::CSC_ST_IDLE;
        end
        else if (~ship_off_delay_select_i | (ms_tick & (seq_ms == `CSC_SHIP_DLY_MS - 20'h00001)))
        begin
          next_seq_ms    = 20'h00000;
          next_batt_hold = power_o.internal_battery_switch; // see RL17
          if (target == `CSC_MODE_SHUT)
            next_state = csc_pkg::CSC_ST_SHUT; // see RL11
          else if (target == `CSC_MODE_SHIP)
            next_state = csc_pkg::CSC_ST_SHIP; // see RL12
          else
            next_state = csc_pkg::CSC_ST_PRST; // see RL16
        end
        else if (ms_tick)
          next_seq_ms = seq_ms + 20'h00001; // see RL14
      end
      csc_pkg::CSC_ST_SHUT:
      begin
        if (adapter_present_i)
        begin
          next_mode  = `CSC_MODE_IDLE; // see RL11
          next_state = csc_pkg::CSC_ST_IDLE;
        end
      end
      csc_pkg::CSC_ST_SHIP:
      begin
        if (adapter_present_i | wake_hold | (mode_wr_i & (mode_wdata_i == `CSC_MODE_IDLE)))
        begin
          next_mode  = `CSC_MODE_IDLE; // see RL15
          next_state = csc_pkg::CSC_ST_IDLE;
        end
      end
      csc_pkg::CSC_ST_PRST:
      begin
        if (ms_tick & (seq_ms == `CSC_RST_OFF_MS - 20'h00001))
        begin
          next_mode  = `CSC_MODE_IDLE; // see RL17
          next_state = csc_pkg::CSC_ST_IDLE;
        end
        else if (ms_tick)
          next_seq_ms = seq_ms + 20'h00001; // see RL16
      end
      default:
      begin
        next_mode  = `CSC_MODE_IDLE;
        next_state = csc_pkg::CSC_ST_IDLE;
      end
    endcase
    // a long button hold starts a power reset from any awake mode
    if (long_hold & (state != csc_pkg::CSC_ST_SHUT) & (state != csc_pkg::CSC_ST_PRST))
    begin
      next_mode      = `CSC_MODE_PRST; // see RL16
      next_seq_ms    = 20'h00000;
      next_batt_hold = power_o.internal_battery_switch;
      next_state     = csc_pkg::CSC_ST_PRST;
    end
    if (reg_reset_i)
    begin
      next_mode  = `CSC_MODE_RESET; // see RL15
      next_state = csc_pkg::CSC_ST_IDLE;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state     <= csc_pkg::CSC_ST_IDLE;
      mode      <= `CSC_MODE_RESET;                       // see RL10
      target    <= `CSC_MODE_RESET;
      seq_ms    <= 20'h00000;
      btn_ms    <= 20'h00000;
      batt_hold <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      mode      <= next_mode;
      target    <= next_target;
      seq_ms    <= next_seq_ms;
      btn_ms    <= next_btn_ms;
      batt_hold <= next_batt_hold;
    end
  end

  // ****************************************************************
  // power path outputs and fault reactions
  // ****************************************************************
  csc_pkg::csc_power_s next_power;
  logic [19:0]         retest_ms;
  logic [19:0]         next_retest_ms;
  logic                weak_hold;
  logic                next_weak_hold;
  logic [1:0]          path_ok;

  // input 0 preferred; input 1 only while 0 unusable
  always_comb
  begin
    path_ok        = input_valid_i & ~cond_i.input_line_overvoltage_fault;
    next_weak_hold = (weak_hold | cond_i.weak_source_fail) & ~cond_i.good_input;
    next_retest_ms = retest_ms;
    next_power     = '0;
    if (~weak_hold)
      next_retest_ms = 20'h00000;
    else if (ms_tick)
      next_retest_ms = (retest_ms == `CSC_RETEST_MS - 20'h00001) ? 20'h00000 : retest_ms + 20'h00001;
    next_power.weak_source_retest = weak_hold & ms_tick & (retest_ms == `CSC_RETEST_MS - 20'h00001); // see RL20
    next_power.ship_gate_driver   = (next_state == csc_pkg::CSC_ST_IDLE) | (next_state == csc_pkg::CSC_ST_DELAY);
    next_power.serial_enable      = next_state != csc_pkg::CSC_ST_SHUT;     // see RL11
    next_power.slow_clock         = next_state == csc_pkg::CSC_ST_SHIP;     // see RL12
    next_power.input_high_impedance_mode = (next_state == csc_pkg::CSC_ST_PRST) & bus_high; // see RL16
    if (next_state == csc_pkg::CSC_ST_PRST)
      next_power.internal_battery_switch = next_batt_hold; // see RL17
    else if (next_power.ship_gate_driver)
      next_power.internal_battery_switch = battery_switch_req_i | cond_i.bus_overvoltage_fault; // see RL19
    else
      next_power.internal_battery_switch = 1'b0; // see RL12
    next_power.input_path_gate_driver[0] = path_ok[0]; // see RL18
    next_power.input_path_gate_driver[1] = path_ok[1] & ~path_ok[0]; // see RL18
    next_power.converter_enable = ~(cond_i.bus_overvoltage_fault            // see RL19
                                  | cond_i.system_overvoltage_fault        // see RL21
                                  | next_weak_hold                          // see RL20
                                  | next_power.input_high_impedance_mode);
    next_power.output_current_limit = cond_i.system_short_fault; // see RL22
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      retest_ms                <= 20'h00000;
      weak_hold                <= 1'b0;
      power_o                  <= '0;
      ship_switch_mode_field_o <= `CSC_MODE_RESET;
    end
    else
    begin
      retest_ms                <= next_retest_ms;
      weak_hold                <= next_weak_hold;
      power_o                  <= next_power;
      ship_switch_mode_field_o <= next_mode;
    end
  end

endmodule

// [dv/csc_host.sv]
// host model that answers alert pulses by reading every flag
`timescale 1ns/100ps
module csc_host
(
  input  wire logic        clk_i,
  input  wire logic        en_i,
  input  wire logic        slow_i,
  input  wire logic        alert_n_i,
  input  wire logic [21:0] flag_i,
  output logic      [21:0] flag_rd_o = '0,
  output logic      [21:0] seen_o = '0
);
  logic last_n = 1'b1;
  // slow host reads at pulse end
  always @(posedge clk_i)
  begin
    last_n <= alert_n_i;
    flag_rd_o <= '0;
    if (en_i && (slow_i ? (alert_n_i && !last_n) : (!alert_n_i && last_n)))
    begin
      flag_rd_o <= '1;
      seen_o <= flag_i;
    end
  end
endmodule

// [dv/csc_sva.sv]
// assertion checker of the charger supervisory block
`timescale 1ns/100ps
`include "csc_regs.svh"
module csc_sva
#(
  parameter int unsigned ALERT_CYC = 8
)
(
  input wire logic                 clk_i,
  input wire logic                 srst_i,
  input wire csc_pkg::csc_cond_s   cond_i,
  input wire logic                 charging_i,
  input wire logic                 fault_suspend_i,
  input wire logic                 indicator_disable_bit_i,
  input wire logic [`CSC_NSRC-1:0] flag_rd_i,
  input wire logic                 mode_wr_i,
  input wire logic [1:0]           mode_wdata_i,
  input wire logic                 ship_off_delay_select_i,
  input wire logic                 adapter_present_i,
  input wire logic                 reverse_boost_mode_i,
  input wire logic                 stat_pin_oe_o,
  input wire logic                 alert_n_o,
  input wire logic [`CSC_NSRC-1:0] status_o,
  input wire logic [`CSC_NSRC-1:0] flag_o,
  input wire logic [1:0]           ship_switch_mode_field_o,
  input wire csc_pkg::csc_power_s  power_o
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // width is a parameter, so count it
  int unsigned low_cnt;
  always_ff @(posedge clk_i)
  begin
    low_cnt <= (srst_i || alert_n_o) ? 0 : low_cnt + 1;
  end
  // immediate ship request, bus low
  sequence s_ship_req;
    mode_wr_i && mode_wdata_i == 2'h2 && !ship_off_delay_select_i && !adapter_present_i
      && !reverse_boost_mode_i && !ship_switch_mode_field_o;
  endsequence
  a_alert_width: assert property ($rose(alert_n_o) |-> low_cnt == ALERT_CYC)
    else $error("bad alert width");
  a_flag_on_edge: assert property ((status_o & ~$past(status_o) & ~flag_o) == '0)
    else $error("flag missed");
  a_flag_clear: assert property (|flag_rd_i |=> (flag_o & $past(flag_rd_i) & ~(status_o & ~$past(status_o))) == '0)
    else $error("flag kept");
  a_ind_on: assert property (charging_i && !fault_suspend_i && !indicator_disable_bit_i |=> stat_pin_oe_o)
    else $error("indicator not pulled");
  a_ind_off: assert property (indicator_disable_bit_i || !charging_i && !fault_suspend_i |=> !stat_pin_oe_o)
    else $error("indicator pulled");
  a_busy_refuse: assert property (mode_wr_i && ^mode_wdata_i && (adapter_present_i || reverse_boost_mode_i)
    && !ship_switch_mode_field_o |=> !ship_switch_mode_field_o)
    else $error("mode taken");
  a_ship_entry: assert property (s_ship_req |=> ship_switch_mode_field_o == 2'h2 ##2 !power_o.ship_gate_driver
    && !power_o.internal_battery_switch && power_o.slow_clock)
    else $error("no ship mode");
  a_bus_ovp: assert property (cond_i.bus_overvoltage_fault |=> !power_o.converter_enable)
    else $error("converter on");
  a_line_ovp: assert property (cond_i.input_line_overvoltage_fault[0] |=> !power_o.input_path_gate_driver[0])
    else $error("path on");
  a_short_lim: assert property (cond_i.system_short_fault |=> power_o.output_current_limit)
    else $error("no limit");
endmodule

bind csc_top csc_sva #(.ALERT_CYC(ALERT_CYC)) csc_sva_inst (.*);

// [dv/testbench.sv]
// self-checking bench of the charger supervisory block
`timescale 1ns/100ps
module testbench;
  // ****************************************************************
  // stimulus and checks
  // ****************************************************************
  logic clk = 1'b0, srst = 1'b1, chg = 1'b0, susp = 1'b0, dis = 1'b0, wr = 1'b0, wsel = 1'b0, btn = 1'b1;
  logic adp = 1'b0, rb = 1'b0, hen = 1'b0, hslow = 1'b0, pin, oe, alert_n;
  logic [1:0] wd = 2'h0, valid = 2'h0, field;
  logic [21:0] mask = '0, rd = '0, status, flag, hrd, seen;
  csc_pkg::csc_cond_s cond = '0;
  csc_pkg::csc_power_s pwr;
  wire sg = pwr.ship_gate_driver, bs = pwr.internal_battery_switch, hz = pwr.input_high_impedance_mode;
  wire [3:0] fp = {pwr.input_path_gate_driver, pwr.converter_enable, pwr.output_current_limit};
  int fails = 0, tests_run = 0, cyc = 0, k, m;
  int cb[20] = '{27, 24, 23, 22, 21, 20, 17, 13, 12, 10, 11, 9, 8, 7, 6, 5, 4, 3, 2, 0};
  csc_top #(.MS_TICK_CYC(10), .ALERT_CYC(8)) csc_top_inst (.clk_i(clk), .srst_i(srst), .cond_i(cond),
    .charging_i(chg), .fault_suspend_i(susp), .indicator_disable_bit_i(dis), .mask_i(mask), .flag_rd_i(rd | hrd),
    .mode_wr_i(wr), .mode_wdata_i(wd), .reg_reset_i(1'b0), .ship_off_delay_select_i(1'b0),
    .wake_hold_time_select_i(wsel), .wake_button_pin_n_i(btn), .adapter_present_i(adp),
    .reverse_boost_mode_i(rb), .battery_switch_req_i(1'b1), .input_valid_i(valid), .stat_pin_o(pin),
    .stat_pin_oe_o(oe), .alert_n_o(alert_n), .status_o(status), .flag_o(flag),
    .ship_switch_mode_field_o(field), .power_o(pwr));
  csc_host csc_host_inst (.clk_i(clk), .en_i(hen), .slow_i(hslow), .alert_n_i(alert_n), .flag_i(flag),
    .flag_rd_o(hrd), .seen_o(seen));
  always #2.5 clk = ~clk;
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic mode(input logic [1:0] v);
    wr <= 1'b1;
    wd <= v;
    tick(1);
    wr <= 1'b0;
  endtask
  task automatic report_and_stop();
    if (fails == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      fails++;
      report_and_stop();
    end
  end
  initial
  begin
    void'($urandom(32'hA62DDFDC));
    tick(20);
    srst <= 1'b0;
    tick(5);
    #1 check({flag[6], alert_n}, 2'h2);
    tick(20);
    // cb[k] feeds source k, or k+1 past 0; random mask
    for (k = 0; k < 20; k++)
    begin
      tick(1);
      m = $urandom % 2;
      cond[cb[k]] <= 1'b1;
      mask[k + (k > 0)] <= m[0];
      tick(2);
      #1 check(flag[k + (k > 0)], 1'b1);
      check(alert_n, m[0]);
      tick(1);
      cond[cb[k]] <= 1'b0;
      tick(30);
      rd <= '1;
      mask <= '0;
      tick(1);
      rd <= '0;
      tick(1);
      #1 check(flag, 0);
    end
    tick(1); chg <= 1'b1;
    tick(2); #1 check(oe, 1'b1);
    tick(1); dis <= 1'b1;
    tick(2); #1 check(oe, 1'b0);
    tick(1); dis <= 1'b0; susp <= 1'b1;
    tick(2500); #1 check(oe, 1'b1);
    tick(5000); #1 check({oe, pin}, 2'h0);
    tick(1); susp <= 1'b0; rb <= 1'b1; mode(2'h2);
    tick(1); #1 check(field, 2'h0);
    tick(1); rb <= 1'b0; wsel <= 1'b1; mode(2'h2);
    tick(3); #1 check({sg, pwr.slow_clock, field}, 4'h6);
    tick(1); btn <= 1'b0;
    tick(200); btn <= 1'b1;
    tick(2); #1 check({sg, bs, field}, 4'hC);
    tick(1); mode(2'h2);
    tick(5); mode(2'h0);
    tick(3); #1 check({sg, field}, 3'h4);
    tick(1); mode(2'h1);
    tick(3); #1 check({sg, pwr.serial_enable, field}, 4'h1);
    tick(1); adp <= 1'b1;
    tick(3); #1 check({sg, pwr.serial_enable, field}, 4'hC);
    tick(1); mode(2'h3);
    tick(3); #1 check({sg, hz, bs, field}, 5'h0F);
    tick(3600); #1 check({sg, hz, bs, field}, 5'h14);
    tick(1); adp <= 1'b0; valid <= 2'h3; cond.good_input <= 1'b1; cond.input_line_overvoltage_fault <= 2'h1;
    cond.bus_overvoltage_fault <= 1'b1; cond.system_short_fault <= 1'b1;
    tick(3); #1 check(fp, 4'h9);
    tick(1); cond.input_line_overvoltage_fault <= 2'h0; cond.bus_overvoltage_fault <= 1'b0; cond.system_short_fault <= 1'b0;
    tick(3); #1 check(fp, 4'h6);
    tick(30); hen <= 1'b1; hslow <= $urandom % 2; cond.other_status <= 2'h2;
    tick(20); #1 check({seen[21], flag[21]}, 2'h2);
    report_and_stop();
  end
endmodule

// [inc/csc_pkg.sv]
// types of the charger alert and ship switch control block
package csc_pkg;

  // one-hot states of the ship switch sequencer
  typedef enum logic [4:0] {
    CSC_ST_IDLE  = 5'h01,
    CSC_ST_DELAY = 5'h02,
    CSC_ST_SHUT  = 5'h04,
    CSC_ST_SHIP  = 5'h08,
    CSC_ST_PRST  = 5'h10
  } csc_state_e;

  // live conditions reported by the analog and charge logic
  typedef struct packed {
    logic       good_input;
    logic [2:0] input_source_kind_field;
    logic       input_current_limit_loop;
    logic       input_voltage_limit_loop;
    logic       die_heat_regulation;
    logic       watchdog_expired;
    logic [2:0] charge_phase_field;
    logic [3:0] thermistor_zone_field;
    logic       bus_overvoltage_fault;
    logic [1:0] input_line_overvoltage_fault;
    logic       die_overheat_cutoff;
    logic       battery_overvoltage_fault;
    logic       system_overvoltage_fault;
    logic       input_overcurrent_fault;
    logic       battery_overcurrent_fault;
    logic       safety_timer_expired;
    logic       system_short_fault;
    logic       weak_source_fail;
    logic [1:0] other_status;
  } csc_cond_s;

  // power path controls driven by the block
  typedef struct packed {
    logic       ship_gate_driver;
    logic       internal_battery_switch;
    logic       serial_enable;
    logic       slow_clock;
    logic       input_high_impedance_mode;
    logic [1:0] input_path_gate_driver;
    logic       converter_enable;
    logic       output_current_limit;
    logic       weak_source_retest;
  } csc_power_s;

endpackage

// [inc/csc_regs.svh]
// constants of the charger alert and ship switch control block
`ifndef CSC_REGS_SVH
`define CSC_REGS_SVH

// ****************************************************************
// timing
// ****************************************************************
`define CSC_CLK_PERIOD_NS 5
`define CSC_MS_NS         1000000
`define CSC_ALERT_US      256
`define CSC_BLINK_HALF_MS 20'd500
`define CSC_SHIP_DLY_MS   20'd10000
`define CSC_WAKE_LONG_MS  20'd1000
`define CSC_WAKE_SHORT_MS 20'd15
`define CSC_RST_HOLD_MS   20'd10000
`define CSC_RST_OFF_MS    20'd350
`define CSC_RETEST_MS     20'd420000

// ****************************************************************
// ship switch mode field codes and reset value
// ****************************************************************
`define CSC_MODE_IDLE  2'h0
`define CSC_MODE_SHUT  2'h1
`define CSC_MODE_SHIP  2'h2
`define CSC_MODE_PRST  2'h3
`define CSC_MODE_RESET 2'h0

// ****************************************************************
// alert source bit positions
// ****************************************************************
`define CSC_SRC_GOOD_IN   0
`define CSC_SRC_GOOD_GONE 1
`define CSC_SRC_KIND_CHG  2
`define CSC_SRC_IIN_LOOP  3
`define CSC_SRC_VIN_LOOP  4
`define CSC_SRC_DIE_HEAT  5
`define CSC_SRC_WATCHDOG  6
`define CSC_SRC_PHASE_CHG 7
`define CSC_SRC_ZONE_CHG  8
`define CSC_SRC_BUS_OVP   9
`define CSC_SRC_LINE_OVP0 10
`define CSC_SRC_LINE_OVP1 11
`define CSC_SRC_DIE_OFF   12
`define CSC_SRC_BAT_OVP   13
`define CSC_SRC_SYS_OVP   14
`define CSC_SRC_IN_OCP    15
`define CSC_SRC_BAT_OCP   16
`define CSC_SRC_SAFETY    17
`define CSC_SRC_SYS_SHORT 18
`define CSC_SRC_WEAK      19
`define CSC_SRC_OTHER0    20
`define CSC_SRC_OTHER1    21
`define CSC_NSRC          22

`endif
